// file: hdl/spm_serial_port1_pin_mux.sv
// The strobed register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
module spm_serial_port1_pin_mux (
	input  wire logic       clock_i,
	input  wire logic       rst_i,
	input  wire logic       link_clk_i,
	input  wire logic [3:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_we_i,
	input  wire logic       reg_re_i,
	output logic      [7:0] reg_rdata_o,
	input  wire logic       stop_i,
	input  wire logic [5:0] pin_in_i,
	output logic      [5:0] pin_out_o,
	output logic      [5:0] pin_oe_o,
	input  wire logic       port_tx_data_i,
	input  wire logic       port_tx1_data_i,
	input  wire logic       port_tx2_data_i,
	input  wire logic       port_flag0_i,
	input  wire logic       port_flag1_i,
	input  wire logic       port_fs_int_i,
	input  wire logic       port_rx_fs_int_i,
	input  wire logic       port_ck_int_i,
	input  wire logic       port_rx_ck_int_i,
	input  wire logic       port_tx_en_i,
	output logic            port_sync_mode_o,
	output logic            port_tx_clk_o,
	output logic            port_rx_clk_o,
	output logic            port_tx_fs_o,
	output logic            port_rx_fs_o,
	output logic            port_rx_data_o,
	output logic            port_flag0_o,
	output logic            port_flag1_o
);
	import spm_pkg::*;

	// ==========================================================
	// Registers
	logic [5:0] ctrl_q, ctrl_d;
	logic [5:0] dir_q, dir_d;
	logic [5:0] data_q, data_d;
	logic [7:0] mode_q, mode_d;
	logic [7:0] rdata_q, rdata_d;
	logic [5:0] gp_meta_q, gp_sync_q;
	spm_pwr_t   pwr_q, pwr_d;
	logic       stop_meta_q, stop_sync_q;
	logic [5:0] oe_q, oe_d;
	logic [5:0] out_q, out_d;

	function automatic logic [7:0] spm_zext6(input logic [5:0] v);
		return {2'h0, v};
	endfunction : spm_zext6

	always_comb begin
		ctrl_d  = ctrl_q;
		dir_d   = dir_q;
		data_d  = data_q;
		mode_d  = mode_q;
		rdata_d = 8'h00;
		if (reg_we_i) begin
			case (reg_addr_i)
				SPM_ADDR_CTRL: ctrl_d = reg_wdata_i[5:0];
				SPM_ADDR_DIR:  dir_d  = reg_wdata_i[5:0];
				SPM_ADDR_DATA: data_d = reg_wdata_i[5:0];
				SPM_ADDR_MODE: mode_d = reg_wdata_i;
				default: ;
			endcase
		end
		if (reg_re_i) begin
			case (reg_addr_i)
				SPM_ADDR_CTRL:   rdata_d = spm_zext6(ctrl_q);
				SPM_ADDR_DIR:    rdata_d = spm_zext6(dir_q);
				SPM_ADDR_DATA:   rdata_d = spm_zext6(gp_sync_q);
				SPM_ADDR_MODE:   rdata_d = mode_q;
				SPM_ADDR_STATUS: rdata_d = {1'b0, (pwr_q == SPM_STOP), oe_q};
				default:         rdata_d = 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Pin routing
	logic sync_m;
	logic stop_now;
	assign sync_m   = mode_q[SPM_MODE_SYNC_BIT];
	assign stop_now = stop_sync_q;

	always_comb begin
		pwr_d = stop_now ? SPM_STOP : SPM_RUN;
		oe_d  = oe_q;
		out_d = out_q;
		if (pwr_d == SPM_RUN) begin
			oe_d  = dir_q & ~ctrl_q;
			out_d = data_q;
			if (ctrl_q[SPM_PIN_C0]) begin
				if (!sync_m) begin
					oe_d[SPM_PIN_C0]  = mode_q[SPM_MODE_C0_OUT];
					out_d[SPM_PIN_C0] = port_rx_ck_int_i;
				end else begin
					oe_d[SPM_PIN_C0]  = mode_q[SPM_MODE_C0_TX] | mode_q[SPM_MODE_C0_OUT];
					out_d[SPM_PIN_C0] = mode_q[SPM_MODE_C0_TX] ? port_tx1_data_i : port_flag0_i;
				end
			end
			if (ctrl_q[SPM_PIN_C1]) begin
				if (!sync_m) begin
					oe_d[SPM_PIN_C1]  = mode_q[SPM_MODE_C1_OUT];
					out_d[SPM_PIN_C1] = port_rx_fs_int_i;
				end else begin
					oe_d[SPM_PIN_C1]  = mode_q[SPM_MODE_C1_TX] | mode_q[SPM_MODE_C1_OUT];
					out_d[SPM_PIN_C1] = mode_q[SPM_MODE_C1_TX] ? port_tx2_data_i : port_flag1_i;
				end
			end
			// internal frame sync driven when output
			if (ctrl_q[SPM_PIN_FS]) begin
				oe_d[SPM_PIN_FS]  = mode_q[SPM_MODE_FS_OUT];
				out_d[SPM_PIN_FS] = port_fs_int_i;
			end
			if (ctrl_q[SPM_PIN_CK]) begin
				oe_d[SPM_PIN_CK]  = mode_q[SPM_MODE_CK_OUT];
				out_d[SPM_PIN_CK] = port_ck_int_i;
			end
			if (ctrl_q[SPM_PIN_RD]) begin
				oe_d[SPM_PIN_RD] = 1'b0;
			end
			if (ctrl_q[SPM_PIN_TD]) begin
				oe_d[SPM_PIN_TD]  = port_tx_en_i;
				out_d[SPM_PIN_TD] = port_tx_data_i;
			end
		end else begin
			oe_d = 6'h00;
		end
	end

	// ==========================================================
	// Link side: bit-clock domain pins come in on the link clock
	// Their consumers sit in the link domain, so only stop and
	// GPIO reads cross into the system domain.
	logic [5:0] lk_meta_q, lk_sync_q;
	always_ff @(posedge link_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lk_meta_q <= 6'h00;
			lk_sync_q <= 6'h00;
		end else begin
			lk_meta_q <= pin_in_i;
			lk_sync_q <= lk_meta_q;
		end
	end

	// link clock tolerates six-phase external periods
	always_comb begin
		port_rx_data_o = lk_sync_q[SPM_PIN_RD] & ctrl_q[SPM_PIN_RD] & ~stop_now;
		port_tx_clk_o  = mode_q[SPM_MODE_CK_OUT] ? port_ck_int_i : lk_sync_q[SPM_PIN_CK];
		port_tx_fs_o   = mode_q[SPM_MODE_FS_OUT] ? port_fs_int_i : lk_sync_q[SPM_PIN_FS];
		if (sync_m) begin
			port_rx_clk_o = port_tx_clk_o;
			port_rx_fs_o  = port_tx_fs_o;
			port_flag0_o  = lk_sync_q[SPM_PIN_C0];
			port_flag1_o  = lk_sync_q[SPM_PIN_C1];
		end else begin
			port_rx_clk_o = mode_q[SPM_MODE_C0_OUT] ? port_rx_ck_int_i : lk_sync_q[SPM_PIN_C0];
			port_rx_fs_o  = mode_q[SPM_MODE_C1_OUT] ? port_rx_fs_int_i : lk_sync_q[SPM_PIN_C1];
			port_flag0_o  = 1'b0;
			port_flag1_o  = 1'b0;
		end
	end
	assign port_sync_mode_o = sync_m;

	// ==========================================================
	// System clock registers
	// reset selects GPIO inputs
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_q      <= SPM_CTRL_RST;
			dir_q       <= SPM_DIR_RST;
			data_q      <= SPM_DATA_RST;
			mode_q      <= SPM_MODE_RST;
			rdata_q     <= 8'h00;
			pwr_q       <= SPM_RUN;
			oe_q        <= 6'h00;
			out_q       <= 6'h00;
			gp_meta_q   <= 6'h00;
			gp_sync_q   <= 6'h00;
			stop_meta_q <= 1'b0;
			stop_sync_q <= 1'b0;
		end else begin
			ctrl_q      <= ctrl_d;
			dir_q       <= dir_d;
			data_q      <= data_d;
			mode_q      <= mode_d;
			rdata_q     <= rdata_d;
			pwr_q       <= pwr_d;
			oe_q        <= oe_d;
			out_q       <= out_d;
			gp_meta_q   <= pin_in_i;
			gp_sync_q   <= gp_meta_q;
			stop_meta_q <= stop_i;
			stop_sync_q <= stop_meta_q;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign pin_oe_o    = oe_q;
	assign pin_out_o   = out_q;

	// ==========================================================
	// Checks
	// Link-side outputs are watched on the system clock, which is
	// at least three times faster than any legal bit clock.
	// Stop request held over two sampled edges
	sequence spm_stop_req_s;
		stop_i ##1 stop_i;
	endsequence
	// Stop released over two sampled edges
	sequence spm_stop_rel_s;
		!stop_i ##1 !stop_i;
	endsequence
	// Read strobe aimed at the control register
	sequence spm_ctrl_read_s;
		reg_re_i && reg_addr_i == SPM_ADDR_CTRL;
	endsequence

	AST_RESET_GPIO_IN: assert property (@(posedge clock_i) $fell(rst_i) |-> pin_oe_o == 6'h00)
		else $error("pins not inputs after reset");
	// direction write reaches pins in two cycles
	AST_GPIO_DIR: assert property (@(posedge clock_i) disable iff (rst_i)
		(reg_we_i && reg_addr_i == SPM_ADDR_DIR && ctrl_q == 6'h00 && !stop_sync_q) ##1 !stop_sync_q
		|=> pin_oe_o == $past(reg_wdata_i[5:0], 2))
		else $error("gpio direction not followed");
	AST_STOP_TRISTATE: assert property (@(posedge clock_i) disable iff (rst_i)
		stop_sync_q |=> pin_oe_o == 6'h00)
		else $error("pin driven during stop");
	// a held stop request reaches the pins
	AST_STOP_ENTER: assert property (@(posedge clock_i) disable iff (rst_i)
		spm_stop_req_s |=> ##1 (pwr_q == SPM_STOP && pin_oe_o == 6'h00))
		else $error("stop not entered in time");
	AST_STOP_LEAVE: assert property (@(posedge clock_i) disable iff (rst_i)
		spm_stop_rel_s |=> ##1 pwr_q == SPM_RUN)
		else $error("stop not left in time");
	AST_STOP_RX_IGNORED: assert property (@(posedge clock_i) disable iff (rst_i)
		stop_sync_q |-> !port_rx_data_o)
		else $error("rx data passed during stop");
	AST_RXD_INPUT: assert property (@(posedge clock_i) disable iff (rst_i)
		ctrl_q[SPM_PIN_RD] && $stable(ctrl_q) |=> !pin_oe_o[SPM_PIN_RD])
		else $error("rx data pin driven");
	AST_TXD_OUT: assert property (@(posedge clock_i) disable iff (rst_i)
		ctrl_q[SPM_PIN_TD] && $stable(ctrl_q) && !stop_sync_q |=> pin_oe_o[SPM_PIN_TD] == $past(port_tx_en_i))
		else $error("tx data enable wrong");
	// tx data pin carries the shifted bit
	AST_TXD_BIT: assert property (@(posedge clock_i) disable iff (rst_i)
		ctrl_q[SPM_PIN_TD] && !stop_sync_q |=> pin_out_o[SPM_PIN_TD] == $past(port_tx_data_i))
		else $error("tx data bit wrong");
	AST_GPIO_DATA: assert property (@(posedge clock_i) disable iff (rst_i)
		!ctrl_q[SPM_PIN_TD] && $stable(ctrl_q) && !stop_sync_q
		|=> pin_out_o[SPM_PIN_TD] == $past(data_q[SPM_PIN_TD]))
		else $error("gpio data not routed");
	AST_CTRL_READBACK: assert property (@(posedge clock_i) disable iff (rst_i)
		spm_ctrl_read_s |=> reg_rdata_o == {2'h0, $past(ctrl_q)})
		else $error("control readback wrong");
	AST_MODE_READBACK: assert property (@(posedge clock_i) disable iff (rst_i)
		reg_re_i && reg_addr_i == SPM_ADDR_MODE |=> reg_rdata_o == $past(mode_q))
		else $error("mode readback wrong");
	AST_CK_DIR: assert property (@(posedge clock_i) disable iff (rst_i)
		ctrl_q[SPM_PIN_CK] && !stop_sync_q |=> pin_oe_o[SPM_PIN_CK] == $past(mode_q[SPM_MODE_CK_OUT]))
		else $error("bit clock direction wrong");
	AST_FS_OUT: assert property (@(posedge clock_i) disable iff (rst_i)
		ctrl_q[SPM_PIN_FS] && mode_q[SPM_MODE_FS_OUT] && $stable(mode_q) && $stable(ctrl_q) && !stop_sync_q
		|=> pin_oe_o[SPM_PIN_FS] && pin_out_o[SPM_PIN_FS] == $past(port_fs_int_i))
		else $error("frame sync not driven");
	// receiver shares frame sync in sync mode
	AST_SYNC_SHARE: assert property (@(posedge clock_i) disable iff (rst_i)
		sync_m |-> port_rx_fs_o == port_tx_fs_o && port_rx_clk_o == port_tx_clk_o)
		else $error("sync mode not shared");
endmodule : spm_serial_port1_pin_mux

// file: include/spm_pkg.sv
package spm_pkg;
	// ==========================================================
	// Register map (word offsets on the plain register port)
	localparam logic [3:0] SPM_ADDR_CTRL   = 4'h0;
	localparam logic [3:0] SPM_ADDR_DIR    = 4'h1;
	localparam logic [3:0] SPM_ADDR_DATA   = 4'h2;
	localparam logic [3:0] SPM_ADDR_MODE   = 4'h3;
	localparam logic [3:0] SPM_ADDR_STATUS = 4'h4;
	localparam int         SPM_NPINS       = 6;
	localparam logic [5:0] SPM_CTRL_RST    = 6'h00;
	localparam logic [5:0] SPM_DIR_RST     = 6'h00;
	localparam logic [5:0] SPM_DATA_RST    = 6'h00;
	// ==========================================================
	// Mode register fields
	localparam int         SPM_MODE_SYNC_BIT  = 0;
	localparam int         SPM_MODE_CK_OUT    = 1;
	localparam int         SPM_MODE_FS_OUT    = 2;
	localparam int         SPM_MODE_C0_OUT    = 3;
	localparam int         SPM_MODE_C1_OUT    = 4;
	localparam int         SPM_MODE_C0_TX     = 5;
	localparam int         SPM_MODE_C1_TX     = 6;
	localparam int         SPM_MODE_STOPHOLD  = 7;
	localparam logic [7:0] SPM_MODE_RST       = 8'h00;
	// Pin indices
	localparam int SPM_PIN_C0 = 0;
	localparam int SPM_PIN_C1 = 1;
	localparam int SPM_PIN_FS = 2;
	localparam int SPM_PIN_CK = 3;
	localparam int SPM_PIN_RD = 4;
	localparam int SPM_PIN_TD = 5;
	// Least external bit-clock period, in system phases (6T)
	localparam int SPM_MIN_EXT_PHASES = 6;
	typedef enum logic [1:0] {
		SPM_RUN  = 2'b00,
		SPM_STOP = 2'b01
	} spm_pwr_t;
endpackage : spm_pkg

// file: verif/spm_far_model.sv
`timescale 1ns/10ps
// ==========================================================
// Far-side codec: frame sync, bit clock and rx data
module spm_far_model (
	input  wire logic       link_clk_i,
	input  wire logic       run_i,
	input  wire logic [7:0] word_i,
	output logic      [2:0] drv_o
);
	logic       run_q;
	logic [2:0] bit_q;
	// Frames start on a falling edge so no sync pulse is cut short
	always_ff @(negedge link_clk_i) begin
		run_q <= run_i;
		bit_q <= run_q ? bit_q + 3'h1 : 3'h0;
	end
	assign drv_o[0] = run_q && (bit_q == 3'h0);
	// slow bit clock, still while run_q is low
	assign drv_o[1] = run_q & link_clk_i;
	// Idle data line shows the inverse of bit 0, never a stale value
	assign drv_o[2] = run_q ? word_i[bit_q] : ~word_i[0];
endmodule : spm_far_model

// file: verif/spm_serial_port1_pin_mux_bench.sv
`timescale 1ns/10ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin error_cnt++; \
	$display("Error %s expected %h seen %h", n, e, s); end end
module spm_serial_port1_pin_mux_bench;
	import spm_pkg::*;
	logic       clock_i, rst_i, link_clk_i, reg_we_i, reg_re_i, stop_i, run;
	logic [3:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, word;
	logic [5:0] pin_in_i, pin_out_o, pin_oe_o;
	logic [2:0] drv;
	logic       port_tx_data_i, port_tx1_data_i, port_tx2_data_i, port_flag0_i, port_flag1_i, port_fs_int_i;
	logic       port_rx_fs_int_i, port_ck_int_i, port_rx_ck_int_i, port_tx_en_i, port_sync_mode_o, port_tx_clk_o;
	logic       port_rx_clk_o, port_tx_fs_o, port_rx_fs_o, port_rx_data_o, port_flag0_o, port_flag1_o;
	int         error_cnt, comparisons, fs_cnt, rfs_cnt;
	spm_serial_port1_pin_mux dut_u (.clock_i, .rst_i, .link_clk_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i,
		.reg_rdata_o, .stop_i, .pin_in_i, .pin_out_o, .pin_oe_o, .port_tx_data_i, .port_tx1_data_i, .port_tx2_data_i,
		.port_flag0_i, .port_flag1_i, .port_fs_int_i, .port_rx_fs_int_i, .port_ck_int_i, .port_rx_ck_int_i,
		.port_tx_en_i, .port_sync_mode_o, .port_tx_clk_o, .port_rx_clk_o, .port_tx_fs_o, .port_rx_fs_o,
		.port_rx_data_o, .port_flag0_o, .port_flag1_o);
	spm_far_model far_u (.link_clk_i(link_clk_i), .run_i(run), .word_i(word), .drv_o(drv));
	// ==========================================================
	// Pin levels: pull-ups on 0, 1 and 5, the codec drives 2 to 4
	assign pin_in_i = (pin_oe_o & pin_out_o) | (~pin_oe_o & {1'b1, drv, 2'b11});
	always #2 clock_i = ~clock_i;
	initial begin
		link_clk_i = 1'b0;
		#1.3;
		forever #6 link_clk_i = ~link_clk_i;
	end
	always @(posedge port_tx_fs_o) fs_cnt++;
	always @(posedge port_rx_fs_o) rfs_cnt++;
	// ==========================================================
	// Register port tasks; a write also waits out the pin and link paths
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock_i);
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		reg_we_i    <= 1'b1;
		@(posedge clock_i);
		reg_we_i    <= 1'b0;
		repeat (12) @(posedge clock_i);
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock_i);
		reg_addr_i <= a;
		reg_re_i   <= 1'b1;
		@(posedge clock_i);
		reg_re_i   <= 1'b0;
		#1;
		`CHK("reg_rdata_o", e, reg_rdata_o)
	endtask : rd
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude
	initial begin
		#40000;
		error_cnt++;
		conclude();
	end
	// ==========================================================
	// Tests
	initial begin
		{clock_i, stop_i, run, reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i, word} = '0;
		{port_tx_data_i, port_tx1_data_i, port_tx2_data_i, port_flag0_i, port_flag1_i, port_fs_int_i} = '0;
		{port_rx_fs_int_i, port_ck_int_i, port_rx_ck_int_i, port_tx_en_i, error_cnt, comparisons} = '0;
		rst_i = 1'b1;
		repeat (3) @(posedge clock_i);
		rst_i <= 1'b0;
		#1;
		`CHK("pin_oe_o", 6'h00, pin_oe_o)
		`CHK("pin_out_o", 6'h00, pin_out_o)
		rd(SPM_ADDR_CTRL, 8'h00);
		rd(SPM_ADDR_MODE, 8'h00);
		rd(4'hf, 8'h00);
		$display("Test reset done");
		wr(SPM_ADDR_DIR, 8'h3f);
		wr(SPM_ADDR_DATA, 8'h2a);
		`CHK("pin_oe_o", 6'h3f, pin_oe_o)
		`CHK("pin_out_o", 6'h2a, pin_out_o)
		rd(SPM_ADDR_DATA, 8'h2a);
		wr(SPM_ADDR_DIR, 8'h15);
		`CHK("pin_oe_o", 6'h15, pin_oe_o)
		rd(SPM_ADDR_DATA, 8'h22);
		rd(SPM_ADDR_STATUS, 8'h15);
		$display("Test gpio done");
		wr(SPM_ADDR_CTRL, 8'h30);
		`CHK("pin_oe_o", 6'h05, pin_oe_o)
		wr(SPM_ADDR_CTRL, 8'h3f);
		`CHK("pin_oe_o", 6'h00, pin_oe_o)
		`CHK("port_rx_clk_o", 1'b1, port_rx_clk_o)
		`CHK("port_rx_fs_o", 1'b1, port_rx_fs_o)
		`CHK("port_tx_clk_o", 1'b0, port_tx_clk_o)
		`CHK("port_tx_fs_o", 1'b0, port_tx_fs_o)
		@(posedge clock_i);
		port_rx_ck_int_i <= 1'b1;
		wr(SPM_ADDR_MODE, 8'h18);
		`CHK("pin_oe_o", 6'h03, pin_oe_o)
		`CHK("pin_out_o[1:0]", 2'b01, pin_out_o[1:0])
		`CHK("port_flag0_o", 1'b0, port_flag0_o)
		$display("Test async done");
		wr(SPM_ADDR_MODE, 8'h01);
		`CHK("port_sync_mode_o", 1'b1, port_sync_mode_o)
		`CHK("port_rx_clk_o", 1'b0, port_rx_clk_o)
		`CHK("port_rx_fs_o", 1'b0, port_rx_fs_o)
		`CHK("port_flag1_o", 1'b1, port_flag1_o)
		`CHK("port_flag0_o", 1'b1, port_flag0_o)
		`CHK("port_rx_data_o", 1'b1, port_rx_data_o)
		word <= 8'h01;
		fs_cnt = 0;
		rfs_cnt = 0;
		run <= 1'b1;
		repeat (44) @(posedge clock_i);
		run <= 1'b0;
		repeat (12) @(posedge clock_i);
		#1;
		`CHK("tx frame syncs", 2, fs_cnt)
		`CHK("rx frame syncs", 2, rfs_cnt)
		`CHK("port_rx_data_o", 1'b0, port_rx_data_o)
		@(posedge clock_i);
		port_tx1_data_i <= 1'b1;
		port_flag1_i    <= 1'b1;
		wr(SPM_ADDR_MODE, 8'h79);
		`CHK("pin_out_o[1:0]", 2'b01, pin_out_o[1:0])
		wr(SPM_ADDR_MODE, 8'h19);
		`CHK("pin_out_o[1:0]", 2'b10, pin_out_o[1:0])
		`CHK("pin_oe_o[1:0]", 2'b11, pin_oe_o[1:0])
		$display("Test sync done");
		@(posedge clock_i);
		{port_fs_int_i, port_ck_int_i, port_tx_en_i, port_tx_data_i} <= 4'hf;
		wr(SPM_ADDR_MODE, 8'h07);
		`CHK("pin_oe_o", 6'h2c, pin_oe_o)
		`CHK("pin_out_o", 6'h2c, pin_out_o & 6'h2c)
		@(posedge clock_i);
		stop_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		#1;
		`CHK("pin_oe_o", 6'h00, pin_oe_o)
		rd(SPM_ADDR_STATUS, 8'h40);
		rd(SPM_ADDR_CTRL, 8'h3f);
		@(posedge clock_i);
		stop_i <= 1'b0;
		repeat (6) @(posedge clock_i);
		#1;
		`CHK("pin_oe_o", 6'h2c, pin_oe_o)
		$display("Test stop done");
		conclude();
	end
endmodule : spm_serial_port1_pin_mux_bench
